//--- logic/sbs_defines.svh
/*
 * Offsets, field positions, widths and reset values of the sideband
 * status register bank.
 * Assumes it is included by bare name from the package and design files.
 */
`ifndef SBS_DEFINES_SVH
`define SBS_DEFINES_SVH

`define SBS_OFS_STATUS 3'h2
`define SBS_OFS_RXLEN 3'h6
`define SBS_RXLEN_W 13
`define SBS_WORD_W 16
`define SBS_OFS_W 3
`define SBS_STATUS_RST 16'h0000
`define SBS_RXLEN_RST 13'h0000
`define SBS_BIT_FAULT 0
`define SBS_BIT_LINK 1
`define SBS_BIT_NEG 2
`define SBS_BIT_TXSEEN 3
`define SBS_BIT_RXSEEN 4
`define SBS_BIT_TRANSMIT_FIFO_EMPTY 5
`define SBS_BIT_DNACT 6
`define SBS_BIT_UPACT 7
`define SBS_BIT_WAKE 8
`define SBS_BIT_REMOTE 9
`define SBS_BIT_GO 10
`define SBS_REQ_W 21

`endif

//--- logic/sbs_link_port.sv
/*
 * Link-clock side of the register access port: takes one request at a
 * time, hands it to the core domain by a toggle, and returns the answer.
 * Assumes the core side toggles its answer only after its data is settled.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defines.svh"
module sbs_link_port (
   // Link clock and reset.
   input wire logic link_clk_in,
   input wire logic link_resetn_in,
   // Requests from the management controller.
   input wire logic link_req_in,
   input wire logic link_write_in,
   input wire sbs_pkg::sbs_ofs_t link_addr_in,
   input wire sbs_pkg::sbs_word_t link_wdata_in,
   output logic link_busy_out,
   output logic link_done_out,
   output sbs_pkg::sbs_word_t link_rdata_out,
   // Toward the core domain.
   output logic [`SBS_REQ_W-1:0] req_out,
   input wire logic ans_tgl_in,
   input wire sbs_pkg::sbs_word_t ans_data_in
);
   import sbs_pkg::*;

   logic [`SBS_WORD_W:0] ans_s;
   logic ans_seen, next_ans_seen, grab, next_grab;
   logic next_busy, next_done;
   logic [`SBS_REQ_W-1:0] next_req;
   sbs_word_t next_rdata;
   logic accept;

   sbs_sync #(.W(`SBS_WORD_W + 1)) u_ans_sync (
      .clk_in(link_clk_in),
      .resetn_in(link_resetn_in),
      .en_in(1'b1),
      .d_in({ans_tgl_in, ans_data_in}),
      .q_out(ans_s)
   );

   // Data is taken one cycle after the toggle edge so it is surely settled.
   always_comb begin
      accept = link_req_in && !link_busy_out;
      next_req = req_out;
      if (accept) begin
         next_req = {!req_out[`SBS_REQ_W-1], link_write_in, link_addr_in,
                     link_wdata_in};
      end
      next_ans_seen = ans_s[`SBS_WORD_W];
      next_grab = ans_s[`SBS_WORD_W] != ans_seen;
      next_done = grab;
      next_rdata = grab ? ans_s[`SBS_WORD_W-1:0] : link_rdata_out;
      next_busy = link_busy_out ? !grab : accept;
   end

   always_ff @(posedge link_clk_in) begin
      if (!link_resetn_in) begin
         req_out <= '0;
         ans_seen <= 1'b0;
         grab <= 1'b0;
         link_done_out <= 1'b0;
         link_rdata_out <= '0;
         link_busy_out <= 1'b0;
      end else begin
         req_out <= next_req;
         ans_seen <= next_ans_seen;
         grab <= next_grab;
         link_done_out <= next_done;
         link_rdata_out <= next_rdata;
         link_busy_out <= next_busy;
      end
   end
endmodule
`default_nettype wire

//--- logic/sbs_pkg.sv
/*
 * Types shared by the sideband status register bank.
 * Assumes sbs_defines.svh is on the include path.
 */
`default_nettype none
`include "sbs_defines.svh"
package sbs_pkg;
   typedef logic [`SBS_WORD_W-1:0] sbs_word_t;
   typedef logic [`SBS_OFS_W-1:0] sbs_ofs_t;
   typedef enum logic [1:0] {CORE_IDLE, CORE_TAKE, CORE_ANSWER} sbs_core_e;
endpackage
`default_nettype wire

//--- logic/sbs_status_regs.sv
/*
 * Sideband status and received-length registers seen by the external
 * management controller, with the remote wake path.
 * Assumes all status inputs come from logic on core_clk_in; register
 * accesses arrive on the link clock and cross by a toggle handshake.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defines.svh"
module sbs_status_regs #(
   parameter int LEN_W = `SBS_RXLEN_W
) (
   // Core clock, reset and enable.
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic core_ce_in,
   // Link clock domain register access.
   input wire logic link_clk_in,
   input wire logic link_resetn_in,
   input wire logic link_req_in,
   input wire logic link_write_in,
   input wire sbs_pkg::sbs_ofs_t link_addr_in,
   input wire sbs_pkg::sbs_word_t link_wdata_in,
   output logic link_busy_out,
   output logic link_done_out,
   output sbs_pkg::sbs_word_t link_rdata_out,
   // Transmit error sources.
   input wire logic tx_max_coll_in,
   input wire logic tx_reclaim_err_in,
   input wire logic tx_jabber_in,
   input wire logic tx_underrun_in,
   // Link and FIFO state.
   input wire logic link_up_now_in,
   input wire logic negotiation_done_in,
   input wire logic transmit_in_progress_in,
   input wire logic fifo_receive_done_in,
   input wire logic transmit_fifo_empty_in,
   input wire logic host_download_active_in,
   input wire logic host_upload_active_in,
   // Received length.
   input wire logic [LEN_W-1:0] rx_byte_count_in,
   input wire logic rx_discard_in,
   // Wake and power management.
   input wire logic wake_detect_in,
   input wire logic wake_mask_mode_in,
   input wire logic power_event_read_in,
   input wire logic wake_status_ack_in,
   input wire logic wake_enable_in,
   output logic pme_n_out,
   output logic wake_forward_out
);
   import sbs_pkg::*;

   //--------------------------------------------------------------------
   // Request crossing
   //--------------------------------------------------------------------
   logic [`SBS_REQ_W-1:0] req_raw;
   logic [`SBS_REQ_W-1:0] req_s;
   logic ans_tgl, next_ans_tgl;
   sbs_word_t ans_data, next_ans_data;

   // The request word crosses as a whole: its toggle bit announces it and
   // the sequencer waits one more cycle before it trusts the other bits.
   sbs_link_port u_link (
      .link_clk_in(link_clk_in),
      .link_resetn_in(link_resetn_in),
      .link_req_in(link_req_in),
      .link_write_in(link_write_in),
      .link_addr_in(link_addr_in),
      .link_wdata_in(link_wdata_in),
      .link_busy_out(link_busy_out),
      .link_done_out(link_done_out),
      .link_rdata_out(link_rdata_out),
      .req_out(req_raw),
      .ans_tgl_in(ans_tgl),
      .ans_data_in(ans_data)
   );

   sbs_sync #(.W(`SBS_REQ_W)) u_req_sync (
      .clk_in(core_clk_in),
      .resetn_in(resetn_in),
      .en_in(core_ce_in),
      .d_in(req_raw),
      .q_out(req_s)
   );

   logic acc_tgl, acc_write;
   sbs_ofs_t acc_addr;
   sbs_word_t acc_wdata;
   assign acc_tgl = req_s[`SBS_REQ_W-1];
   assign acc_write = req_s[`SBS_REQ_W-2];
   assign acc_addr = req_s[`SBS_REQ_W-3 -: `SBS_OFS_W];
   assign acc_wdata = req_s[`SBS_WORD_W-1:0];

   //--------------------------------------------------------------------
   // Access sequencer
   //--------------------------------------------------------------------
   sbs_core_e state, next_state;
   logic req_seen, next_req_seen;
   logic do_acc, rd_status, wr_status, rd_len;

   // Only one access is in flight, so each answer toggle follows one
   // request toggle and the link side never sees two answers at once.
   always_comb begin
      next_state = state;
      next_req_seen = req_seen;
      unique case (state)
         CORE_IDLE: begin
            if (acc_tgl != req_seen) begin
               next_req_seen = acc_tgl;
               next_state = CORE_TAKE;
            end
         end
         CORE_TAKE: next_state = CORE_ANSWER;
         CORE_ANSWER: next_state = CORE_IDLE;
      endcase
      do_acc = state == CORE_TAKE;
      rd_status = do_acc && !acc_write && acc_addr == `SBS_OFS_STATUS;
      wr_status = do_acc && acc_write && acc_addr == `SBS_OFS_STATUS;
      rd_len = do_acc && !acc_write && acc_addr == `SBS_OFS_RXLEN;
   end

   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         state <= CORE_IDLE;
         req_seen <= 1'b0;
      end else if (core_ce_in) begin
         state <= next_state;
         req_seen <= next_req_seen;
      end
   end

   //--------------------------------------------------------------------
   // Status bits
   //--------------------------------------------------------------------
   function automatic logic sticky(input logic cur, input logic set,
                                   input logic clr);
      sticky = set || (cur && !clr);
   endfunction

   logic tx_seen, rx_seen, pending_wake, remote_wake, go_flag;
   logic next_tx_seen, next_rx_seen, next_pending_wake;
   logic next_remote_wake, next_go_flag, next_pme_n, next_wake_forward;
   logic [LEN_W-1:0] rx_len, next_rx_len;
   logic masked_wake;
   sbs_word_t status_word;

   always_comb begin
      status_word = `SBS_STATUS_RST;
      status_word[`SBS_BIT_FAULT] = tx_max_coll_in || tx_reclaim_err_in ||
                                    tx_jabber_in || tx_underrun_in;
      status_word[`SBS_BIT_LINK] = link_up_now_in;
      status_word[`SBS_BIT_NEG] = negotiation_done_in;
      status_word[`SBS_BIT_TXSEEN] = tx_seen;
      status_word[`SBS_BIT_RXSEEN] = rx_seen;
      status_word[`SBS_BIT_TRANSMIT_FIFO_EMPTY] = transmit_fifo_empty_in;
      status_word[`SBS_BIT_DNACT] = host_download_active_in;
      status_word[`SBS_BIT_UPACT] = host_upload_active_in;
      status_word[`SBS_BIT_WAKE] = pending_wake;
      status_word[`SBS_BIT_REMOTE] = remote_wake;
      status_word[`SBS_BIT_GO] = go_flag;
      masked_wake = wake_detect_in && wake_mask_mode_in;
      // A set arriving with a clear always wins.
      next_tx_seen = sticky(tx_seen, transmit_in_progress_in,
                            rd_status);
      next_rx_seen = sticky(rx_seen, fifo_receive_done_in, rd_status);
      next_pending_wake = sticky(pending_wake, masked_wake,
         power_event_read_in ||
         (wr_status && !acc_wdata[`SBS_BIT_WAKE]));
      next_remote_wake = sticky(remote_wake,
         wr_status && acc_wdata[`SBS_BIT_REMOTE], wake_status_ack_in);
      next_go_flag = wr_status ? acc_wdata[`SBS_BIT_GO] : go_flag;
      next_pme_n = !(remote_wake && wake_enable_in);
      next_wake_forward = wake_detect_in && !wake_mask_mode_in;
      next_rx_len = rx_discard_in ? rx_byte_count_in : rx_len;
      next_ans_data = ans_data;
      if (rd_status) begin
         next_ans_data = status_word;
      end else if (rd_len) begin
         next_ans_data = `SBS_WORD_W'(rx_len);
      end else if (do_acc) begin
         next_ans_data = '0;
      end
      next_ans_tgl = (state == CORE_ANSWER) ? !ans_tgl : ans_tgl;
   end

   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         tx_seen <= 1'b0;
         rx_seen <= 1'b0;
         pending_wake <= 1'b0;
         remote_wake <= 1'b0;
         go_flag <= 1'b0;
         pme_n_out <= 1'b1;
         wake_forward_out <= 1'b0;
         rx_len <= `SBS_RXLEN_RST;
         ans_data <= '0;
         ans_tgl <= 1'b0;
      end else if (core_ce_in) begin
         tx_seen <= next_tx_seen;
         rx_seen <= next_rx_seen;
         pending_wake <= next_pending_wake;
         remote_wake <= next_remote_wake;
         go_flag <= next_go_flag;
         pme_n_out <= next_pme_n;
         wake_forward_out <= next_wake_forward;
         rx_len <= next_rx_len;
         ans_data <= next_ans_data;
         ans_tgl <= next_ans_tgl;
      end
   end

   //--------------------------------------------------------------------
   // Checks
   //--------------------------------------------------------------------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);

   chk_len_readout: assert property (
      core_ce_in && rd_len |=> ans_data[`SBS_WORD_W-1:LEN_W] == '0 &&
      ans_data[LEN_W-1:0] == $past(rx_len))
      else $error("length read answer wrong");
   chk_len_hold: assert property (
      core_ce_in && !rx_discard_in |=> $stable(rx_len))
      else $error("length changed without discard");
   chk_status_word: assert property (
      core_ce_in && rd_status |=> ans_data[`SBS_BIT_FAULT] ==
      $past(tx_max_coll_in || tx_reclaim_err_in || tx_jabber_in ||
            tx_underrun_in) && ans_data[`SBS_BIT_LINK] ==
      $past(link_up_now_in) && ans_data[`SBS_BIT_TRANSMIT_FIFO_EMPTY] ==
      $past(transmit_fifo_empty_in))
      else $error("status word does not match sources");
   chk_reserved_zero: assert property (
      core_ce_in && rd_status ##1 state == CORE_ANSWER |->
      ans_data[`SBS_WORD_W-1:11] == '0)
      else $error("reserved status bits not zero");
   chk_tx_seen_set: assert property (
      core_ce_in && transmit_in_progress_in |=> tx_seen)
      else $error("transmit seen not set");
   chk_rx_seen_clear: assert property (
      core_ce_in && rd_status && !fifo_receive_done_in |=> !rx_seen)
      else $error("receive seen not cleared by read");
   chk_mask_wake: assert property (
      core_ce_in && masked_wake |=> pending_wake && !wake_forward_out)
      else $error("masked wake handled wrong");
   chk_pending_clear: assert property (
      core_ce_in && power_event_read_in && !masked_wake |=> !pending_wake)
      else $error("pending wake not cleared");
   chk_remote_hold: assert property (
      core_ce_in && remote_wake && !wake_status_ack_in |=> remote_wake)
      else $error("remote wake dropped early");
   chk_pme_gate: assert property (
      core_ce_in |=> pme_n_out == !$past(remote_wake && wake_enable_in))
      else $error("wake output not gated by enable");
   chk_rx_seen_set: assert property (
      core_ce_in && fifo_receive_done_in |=> rx_seen)
      else $error("receive seen not set");
   chk_tx_seen_clear: assert property (
      core_ce_in && rd_status && !transmit_in_progress_in |=> !tx_seen)
      else $error("transmit seen not cleared by read");
   chk_live_bits: assert property (
      core_ce_in && rd_status |=>
      ans_data[`SBS_BIT_NEG] == $past(negotiation_done_in) &&
      ans_data[`SBS_BIT_DNACT] == $past(host_download_active_in) &&
      ans_data[`SBS_BIT_UPACT] == $past(host_upload_active_in))
      else $error("live status bits wrong");
   chk_remote_set: assert property (
      core_ce_in && wr_status && acc_wdata[`SBS_BIT_REMOTE] |=> remote_wake)
      else $error("remote wake not set by write");
   chk_remote_clear: assert property (
      core_ce_in && wake_status_ack_in &&
      !(wr_status && acc_wdata[`SBS_BIT_REMOTE]) |=> !remote_wake)
      else $error("remote wake not cleared by acknowledge");
   chk_go_write: assert property (
      core_ce_in && wr_status |=> go_flag == $past(acc_wdata[`SBS_BIT_GO]))
      else $error("transmit go flag not written");
   chk_wake_write: assert property (
      core_ce_in && wr_status && !acc_wdata[`SBS_BIT_WAKE] && !masked_wake
      |=> !pending_wake)
      else $error("pending wake not cleared by write");
   chk_len_load: assert property (
      core_ce_in && rx_discard_in |=> rx_len == $past(rx_byte_count_in))
      else $error("length not loaded on discard");
   chk_wake_forward: assert property (
      core_ce_in && wake_detect_in && !wake_mask_mode_in |=> wake_forward_out)
      else $error("unmasked wake not forwarded");
   chk_pme_idle: assert property (
      core_ce_in && !wake_enable_in |=> pme_n_out)
      else $error("wake output active without enable");
   chk_unmapped_zero: assert property (
      core_ce_in && do_acc && !rd_status && !rd_len |=> ans_data == '0)
      else $error("unmapped or write answer not zero");
   chk_enable_freeze: assert property (
      !core_ce_in |=> $stable(tx_seen) && $stable(rx_seen) &&
      $stable(pending_wake) && $stable(state))
      else $error("state moved while clock enable low");

   //--------------------------------------------------------------------
   // Coverage
   //--------------------------------------------------------------------
   cov_status_read: cover property (rd_status ##2 state == CORE_IDLE);
   cov_remote_pme: cover property (!pme_n_out ##[1:50] pme_n_out);
   cov_masked_wake: cover property (masked_wake ##[1:50] rd_status);
   cov_len_load: cover property (rx_discard_in ##[1:200] rd_len);
   cov_ce_freeze: cover property (!core_ce_in ##1 core_ce_in);
endmodule
`default_nettype wire

//--- logic/sbs_sync.sv
/*
 * Two-stage synchroniser for a bundle of bits held stable by a handshake.
 * Assumes the bundle only changes while its consumer ignores it.
 */
`timescale 1ns/1ps
`default_nettype none
module sbs_sync #(
   parameter int W = 1
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic en_in,
   // Data.
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   always_comb begin
      next_meta = en_in ? d_in : meta;
      next_q = en_in ? meta : q_out;
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         meta <= '0;
         q_out <= '0;
      end else begin
         meta <= next_meta;
         q_out <= next_q;
      end
   end
endmodule
`default_nettype wire

//--- tb/sbs_mgmt_model.sv
/*
 * Behavioural management controller: issues register accesses on the
 * link clock and polls status flags.
 * Assumes the bench releases both resets before calling its tasks.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defines.svh"
module sbs_mgmt_model (
   // Link clock.
   input wire logic link_clk_in,
   // Requests.
   output logic link_req_out,
   output logic link_write_out,
   output sbs_pkg::sbs_ofs_t link_addr_out,
   output sbs_pkg::sbs_word_t link_wdata_out,
   // Answers.
   input wire logic link_busy_in,
   input wire logic link_done_in,
   input wire sbs_pkg::sbs_word_t link_rdata_in
);
   import sbs_pkg::*;
   initial begin
      link_req_out = 1'b0;
      link_write_out = 1'b0;
      link_addr_out = 3'h0;
      link_wdata_out = 16'h0000;
   end
   // The request stands until taken; released lines show inverted values.
   task automatic access(input logic w, input sbs_ofs_t a,
         input sbs_word_t d, output sbs_word_t q);
      int n;
      q = 16'hxxxx;
      @(posedge link_clk_in);
      link_req_out <= 1'b1;
      link_write_out <= w;
      link_addr_out <= a;
      link_wdata_out <= d;
      do @(posedge link_clk_in); while (link_busy_in !== 1'b0);
      link_req_out <= 1'b0;
      link_write_out <= ~w;
      link_addr_out <= ~a;
      link_wdata_out <= ~d;
      for (n = 0; n < 40; n++) begin
         @(posedge link_clk_in);
         if (link_done_in === 1'b1) begin
            q = link_rdata_in;
            break;
         end
      end
   endtask
   // Polls one status flag until it shows the wanted value.
   task automatic poll(input int b, input logic v, output logic ok);
      sbs_word_t q;
      int n;
      ok = 1'b0;
      for (n = 0; n < 8 && !ok; n++) begin
         access(1'b0, `SBS_OFS_STATUS, 16'h0000, q);
         ok = (q[b] === v);
      end
   endtask
endmodule
`default_nettype wire

//--- tb/sbs_status_regs_test.sv
/*
 * Self-checking bench for the sideband status register bank.
 * Assumes the management model drives the link side and the bench
 * drives every core-domain status input.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defines.svh"
`define CHK(g, e) begin \
   checks++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("MISMATCH %0t got %h expected %h", $time, (g), (e)); \
   end \
end
module sbs_status_regs_test;
   import sbs_pkg::*;
   logic core_clk = 1'b0;
   logic link_clk = 1'b0;
   logic resetn, link_resetn, mask, wen;
   logic [9:0] lv;
   logic [4:0] pv;
   logic [12:0] rx_cnt;
   logic req, wr_en, busy, done, pme_n, fwd, ok, ce;
   sbs_ofs_t addr;
   sbs_word_t wdata, rdata, q;
   int n_errors = 0;
   int checks = 0;
   // Status bit that each source line lv[0] to lv[8] lands on.
   function automatic int bit_of(input int i);
      return (i < 4) ? 0 : ((i < 6) ? i - 3 : i - 1);
   endfunction
   localparam sbs_ofs_t ST = `SBS_OFS_STATUS;
   localparam sbs_ofs_t LN = `SBS_OFS_RXLEN;

   always #2.5 core_clk = ~core_clk;
   always #16 link_clk = ~link_clk;

   sbs_status_regs dut (
      .core_clk_in(core_clk), .resetn_in(resetn), .core_ce_in(ce),
      .link_clk_in(link_clk), .link_resetn_in(link_resetn),
      .link_req_in(req), .link_write_in(wr_en), .link_addr_in(addr),
      .link_wdata_in(wdata), .link_busy_out(busy), .link_done_out(done),
      .link_rdata_out(rdata),
      .tx_max_coll_in(lv[0]), .tx_reclaim_err_in(lv[1]),
      .tx_jabber_in(lv[2]), .tx_underrun_in(lv[3]),
      .link_up_now_in(lv[4]), .negotiation_done_in(lv[5]),
      .transmit_fifo_empty_in(lv[6]), .host_download_active_in(lv[7]),
      .host_upload_active_in(lv[8]), .transmit_in_progress_in(lv[9]),
      .fifo_receive_done_in(pv[0]), .rx_byte_count_in(rx_cnt),
      .rx_discard_in(pv[1]), .wake_detect_in(pv[2]),
      .wake_mask_mode_in(mask), .power_event_read_in(pv[3]),
      .wake_status_ack_in(pv[4]), .wake_enable_in(wen),
      .pme_n_out(pme_n), .wake_forward_out(fwd)
   );
   sbs_mgmt_model mm (
      .link_clk_in(link_clk), .link_req_out(req), .link_write_out(wr_en),
      .link_addr_out(addr), .link_wdata_out(wdata), .link_busy_in(busy),
      .link_done_in(done), .link_rdata_in(rdata)
   );

   task automatic rd(input sbs_ofs_t a);
      mm.access(1'b0, a, 16'h0000, q);
   endtask
   task automatic wr(input sbs_ofs_t a, input sbs_word_t d);
      mm.access(1'b1, a, d, q);
   endtask
   task automatic pulse(input int i);
      @(posedge core_clk);
      pv <= 5'h01 << i;
      @(posedge core_clk);
      pv <= 5'h00;
   endtask
   task automatic results;
      if (n_errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      #100000;
      n_errors++;
      results();
   end

   initial begin
      resetn = 1'b0;
      link_resetn = 1'b0;
      lv = 10'h000;
      pv = 5'h00;
      mask = 1'b0;
      wen = 1'b0;
      ce = 1'b1;
      rx_cnt = 13'h0000;
      repeat (6) @(posedge link_clk);
      @(posedge core_clk);
      resetn <= 1'b1;
      link_resetn <= 1'b1;
      repeat (2) @(posedge link_clk);
      rd(ST);
      `CHK(q, `SBS_STATUS_RST)
      rd(LN);
      `CHK(q, 16'h0000)
      rd(3'h7);
      `CHK(q, 16'h0000)
      for (int i = 0; i < 9; i++) begin
         @(posedge core_clk);
         lv <= 10'h001 << i;
         rd(ST);
         `CHK(q, 16'h0001 << bit_of(i))
      end
      @(posedge core_clk);
      lv <= 10'h040;
      mm.poll(5, 1'b1, ok);
      `CHK(ok, 1'b1)
      mm.poll(6, 1'b0, ok);
      `CHK(ok, 1'b1)
      mm.poll(7, 1'b0, ok);
      `CHK(ok, 1'b1)
      wr(ST, 16'h0400);
      rd(ST);
      `CHK(q, 16'h0420)
      // A short transmit burst and a receive pulse both stick.
      @(posedge core_clk);
      lv <= 10'h200;
      @(posedge core_clk);
      lv <= 10'h000;
      pulse(0);
      rd(ST);
      `CHK(q, 16'h0418)
      rd(ST);
      `CHK(q, 16'h0400)
      wr(ST, 16'hFFFF);
      rd(ST);
      `CHK(q, 16'h0600)
      `CHK(pme_n, 1'b1)
      @(posedge core_clk);
      wen <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1 `CHK(pme_n, 1'b0)
      rd(ST);
      `CHK(pme_n, 1'b0)
      pulse(4);
      repeat (2) @(posedge core_clk);
      #1 `CHK(pme_n, 1'b1)
      rd(ST);
      `CHK(q, 16'h0400)
      @(posedge core_clk);
      wen <= 1'b0;
      mask <= 1'b1;
      pulse(2);
      #1 `CHK(fwd, 1'b0)
      `CHK(pme_n, 1'b1)
      rd(ST);
      `CHK(q, 16'h0500)
      wr(ST, 16'h0000);
      rd(ST);
      `CHK(q, 16'h0000)
      pulse(2);
      pulse(3);
      rd(ST);
      `CHK(q, 16'h0000)
      @(posedge core_clk);
      mask <= 1'b0;
      pulse(2);
      #1 `CHK(fwd, 1'b1)
      rd(ST);
      `CHK(q, 16'h0000)
      // A receive pulse while the clock enable is low is lost.
      @(posedge core_clk);
      ce <= 1'b0;
      pulse(0);
      @(posedge core_clk);
      ce <= 1'b1;
      rd(ST);
      `CHK(q, 16'h0000)
      // The length only moves on a discard, never on a write.
      @(posedge core_clk);
      rx_cnt <= 13'h1FFF;
      pulse(1);
      @(posedge core_clk);
      rx_cnt <= 13'h0123;
      rd(LN);
      `CHK(q, 16'h1FFF)
      wr(LN, 16'hFFFF);
      rd(LN);
      `CHK(q, 16'h1FFF)
      pulse(1);
      rd(LN);
      `CHK(q, 16'h0123)
      results();
   end
endmodule
`default_nettype wire
